// *** ttec_consts.vh ***
// What this block does
// - Three 16-bit counters read as byte pairs.
// - Counters 0,1 timer/event/pulse; counter 2 timer.
// - Counter 0 uses system clock/4 or pin.
// - Counter 1 uses 32768Hz clock or pin.
// - Counter 2 uses system clock only.
// - Each selected pin edge adds exactly one.
// - Increment per tick; FFFFH overflow raises request.
// - Overflow reloads preload and keeps counting.
// - Preload write when stopped loads counter too.
// - Preload write while running waits for overflow.
// - Low byte write goes to holding buffer.
// - High byte write commits both bytes together.
// - High byte read captures counter low byte.
// - Low byte read returns captured buffer only.
// - Control bits 7:6 select mode; 11 pulse.
// - Control bit 4 is run control.
// - Edge bit 3 low rising, high falling.
// - Pulse mode counts during pulse, clears run.
`ifndef TTEC_CONSTS_VH
`define TTEC_CONSTS_VH
`define TTEC_CNT_W        16
`define TTEC_OFF_LOW      4'h0
`define TTEC_OFF_HIGH     4'h4
`define TTEC_OFF_CTRL     4'h8
`define TTEC_CH_STRIDE_B  4
`define TTEC_MODE_HI      7
`define TTEC_MODE_LO      6
`define TTEC_RUN_BIT      4
`define TTEC_EDGE_BIT     3
`define TTEC_MODE_TIMER   2'h2
`define TTEC_MODE_EVENT   2'h1
`define TTEC_MODE_PULSE   2'h3
`define TTEC_CTRL_RST     8'h00
`define TTEC_PRE_RST      16'h0000
`define TTEC_CNT_MAX      16'hFFFF
`define TTEC_DIV4_MAX     2'h3
`define TTEC_RESP_OKAY    2'h0
`define TTEC_RESP_SLVERR  2'h2
`endif

// *** ttec_counter.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ttec_consts.vh"
module ttec_counter #(
  parameter HAS_PIN = 1
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        tick,
  input  wire        pinSync,
  input  wire        wrLow,
  input  wire        wrHigh,
  input  wire        wrCtrl,
  input  wire        rdHigh,
  input  wire [7:0]  wrData,
  output reg  [15:0] count_q,
  output reg  [7:0]  ctrl_q,
  output reg  [7:0]  lowBuf_q,
  output reg         ovf_q
);
  reg  [15:0] preload_q;
  reg         pinDly_q;
  reg         inPulse_q;
  wire [1:0]  mode    = ctrl_q[`TTEC_MODE_HI:`TTEC_MODE_LO];
  wire        run     = ctrl_q[`TTEC_RUN_BIT];
  wire        edgeSel = ctrl_q[`TTEC_EDGE_BIT];
  wire        rise    = pinSync & ~pinDly_q;
  wire        fall    = ~pinSync & pinDly_q;
  wire        evMode  = (HAS_PIN != 0) && (mode == `TTEC_MODE_EVENT);
  wire        pwMode  = (HAS_PIN != 0) && (mode == `TTEC_MODE_PULSE);
  // Pulse start edge: edge bit low waits for a fall, high for a rise.
  wire        pwStart = edgeSel ? rise : fall;
  wire        pwEnd   = edgeSel ? fall : rise;
  wire        evEdge  = edgeSel ? fall : rise;
  reg         inc;
  always @* begin
    if (!run) begin
      inc = 1'b0;
    end else if (evMode) begin
      inc = evEdge;
    end else if (pwMode) begin
      inc = inPulse_q & tick & ~pwEnd;
    end else begin
      inc = tick;
    end
  end
  wire [15:0] newPre = {wrData, lowBuf_q};
  always @(posedge clock) begin
    if (sys_rst) begin
      count_q   <= `TTEC_PRE_RST;
      preload_q <= `TTEC_PRE_RST;
      ctrl_q    <= `TTEC_CTRL_RST;
      lowBuf_q  <= 8'h00;
      ovf_q     <= 1'b0;
      pinDly_q  <= 1'b0;
      inPulse_q <= 1'b0;
    end else begin
      pinDly_q <= pinSync;
      ovf_q    <= inc && (count_q == `TTEC_CNT_MAX);
      if (wrLow) begin
        lowBuf_q <= wrData;
      end else if (rdHigh) begin
        lowBuf_q <= count_q[7:0];
      end
      if (wrHigh) begin
        preload_q <= newPre;
      end
      if (wrHigh && !run) begin
        count_q <= newPre;
      end else if (inc) begin
        if (count_q == `TTEC_CNT_MAX) begin
          count_q <= wrHigh ? newPre : preload_q;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
      if (wrCtrl) begin
        ctrl_q    <= wrData;
        inPulse_q <= 1'b0;
      end else if (pwMode && run) begin
        if (!inPulse_q && pwStart) begin
          inPulse_q <= 1'b1;
        end else if (inPulse_q && pwEnd) begin
          inPulse_q <= 1'b0;
          ctrl_q[`TTEC_RUN_BIT] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** ttec_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ttec_consts.vh"
module ttec_top (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        cnt0ExtPin,
  input  wire        cnt1ExtPin,
  input  wire        lfClk,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [2:0]  ovfIrq_q
);
  // Channel n sits at byte 16*n: low byte +0, high byte +4, control +8.
  function [2:0] decode;
    input [5:0] a;
    begin
      decode = 3'h0;
      if (a[5:4] == 2'h3) begin
        decode = 3'h0;
      end else if (a[3:0] == `TTEC_OFF_LOW) begin
        decode = 3'h1;
      end else if (a[3:0] == `TTEC_OFF_HIGH) begin
        decode = 3'h2;
      end else if (a[3:0] == `TTEC_OFF_CTRL) begin
        decode = 3'h4;
      end
    end
  endfunction
  reg         p0Meta_q;
  reg         p0Sync_q;
  reg         p1Meta_q;
  reg         p1Sync_q;
  reg         lfMeta_q;
  reg         lfSync_q;
  reg         lfDly_q;
  reg  [1:0]  div_q;
  reg  [5:0]  awAddr_q;
  reg  [31:0] wData_q;
  reg        wStrb_q;
  reg        awHave_q, wHave_q;
  wire [15:0] cnt [0:2];
  wire [7:0]  ctl [0:2];
  wire [7:0]  lbf [0:2];
  wire [2:0]  ovf;
  always @(posedge clock) begin
    if (sys_rst) begin
      p0Meta_q <= 1'b0;
      p0Sync_q <= 1'b0;
      p1Meta_q <= 1'b0;
      p1Sync_q <= 1'b0;
      lfMeta_q <= 1'b0;
      lfSync_q <= 1'b0;
      lfDly_q  <= 1'b0;
      div_q    <= 2'h0;
    end else begin
      p0Meta_q <= cnt0ExtPin;
      p0Sync_q <= p0Meta_q;
      p1Meta_q <= cnt1ExtPin;
      p1Sync_q <= p1Meta_q;
      lfMeta_q <= lfClk;
      lfSync_q <= lfMeta_q;
      lfDly_q  <= lfSync_q;
      div_q    <= (div_q == `TTEC_DIV4_MAX) ? 2'h0 : div_q + 2'h1;
    end
  end
  // Slow clock is sampled, so it must stay well below the system clock.
  wire tick0 = (div_q == `TTEC_DIV4_MAX);
  wire tick1 = lfSync_q & ~lfDly_q;
  wire [2:0] ticks = {1'b1, tick1, tick0};
  wire [2:0] pins  = {1'b0, p1Sync_q, p0Sync_q};
  wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  wire doRead  = s_axi_arvalid && s_axi_arready;
  wire [2:0] wDec = decode(awAddr_q);
  wire [2:0] rDec = decode(s_axi_araddr);
  wire [1:0] wCh  = awAddr_q[5:4];
  wire [1:0] rCh  = s_axi_araddr[5:4];
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gCnt
      wire wSel = doWrite && wStrb_q && (wCh == g);
      ttec_counter #(.HAS_PIN(g < 2)) uCnt (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (ticks[g]),
        .pinSync (pins[g]),
        .wrLow   (wSel && wDec[0]),
        .wrHigh  (wSel && wDec[1]),
        .wrCtrl  (wSel && wDec[2]),
        .rdHigh  (doRead && (rCh == g) && rDec[1]),
        .wrData  (wData_q[7:0]),
        .count_q (cnt[g]),
        .ctrl_q  (ctl[g]),
        .lowBuf_q(lbf[g]),
        .ovf_q   (ovf[g])
      );
    end
  endgenerate
  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TTEC_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `TTEC_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= 6'h00;
      wData_q       <= 32'h00000000;
      wStrb_q       <= 1'b0;
      ovfIrq_q      <= 3'h0;
    end else begin
      ovfIrq_q <= ovf;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q      <= s_axi_awaddr;
        awHave_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb[0];
        wHave_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wDec == 3'h0) ? `TTEC_RESP_SLVERR : `TTEC_RESP_OKAY;
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (doRead) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= (rDec == 3'h0) ? `TTEC_RESP_SLVERR : `TTEC_RESP_OKAY;
        if (rDec[0]) begin
          s_axi_rdata <= {24'h000000, lbf[rCh]};
        end else if (rDec[1]) begin
          s_axi_rdata <= {24'h000000, cnt[rCh][15:8]};
        end else if (rDec[2]) begin
          s_axi_rdata <= {24'h000000, ctl[rCh]};
        end else begin
          s_axi_rdata <= 32'h00000000;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** ttec_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ttec_props (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [2:0]  ovfIrq_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("late bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("late rvalid");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper data set");
  a_bad_slverr: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[5:4] == 2'h3 |=> s_axi_rresp == 2'h2) else $error("no slverr");
  a_irq_single: assert property (|ovfIrq_q |=> (ovfIrq_q & $past(ovfIrq_q)) == 3'h0)
    else $error("long irq");
  a_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready early");
  cover property (ovfIrq_q[2]);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// *** ttec_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ttec_pin_model (
  input  wire logic       clock,
  output var  logic [1:0] pin,
  output var  logic       lfClk
);
  initial begin
    pin = 2'h0;
    lfClk = 1'b0;
    forever #15259 lfClk = ~lfClk;
  end
  // Each level stands len cycles so the synchroniser cannot miss it.
  task automatic pulses(input int ch, input int n, input logic idle, input int len);
    pin[ch] <= idle;
    repeat (n) begin
      repeat (len) @(posedge clock);
      pin[ch] <= ~idle;
      repeat (len) @(posedge clock);
      pin[ch] <= idle;
    end
    repeat (len) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// *** ttec_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ttec_consts.vh"
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module ttec_tb_top;
  logic        clock, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lfClk;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, pin;
  wire  [31:0] s_axi_rdata;
  wire  [2:0]  ovfIrq_q;
  logic [1:0]  resp;
  logic [7:0]  v;
  logic [15:0] w;
  int          errTotal, cmpCount, cyc;
  ttec_top DUT (.clock, .sys_rst, .cnt0ExtPin(pin[0]), .cnt1ExtPin(pin[1]), .lfClk,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ovfIrq_q);
  ttec_pin_model pm (.clock, .pin, .lfClk);
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin do @(posedge clock); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge clock); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge clock); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr16(input logic [5:0] b, input logic [15:0] x);
    wr(b, x[7:0]);
    wr(b + 6'h04, x[15:8]);
  endtask
  task automatic rd16(input logic [5:0] b, output logic [15:0] x);
    rd(b + 6'h04, x[15:8]);
    rd(b, x[7:0]);
  endtask
  task automatic tBuffer;
    rd(6'h28, v);
    `CHK("ctrl rst", 8'h00, v);
    wr(6'h20, 8'h34);
    rd16(6'h20, w);
    `CHK("held", 16'h0000, w);
    // The high read above recaptured the buffer, so the low byte is written again.
    wr(6'h20, 8'h34);
    wr(6'h24, 8'h12);
    rd16(6'h20, w);
    `CHK("loaded", 16'h1234, w);
  endtask
  task automatic tReload;
    logic [7:0] l;
    wr16(6'h20, 16'hFFE0);
    wr(6'h28, 8'h10);
    wr16(6'h20, 16'h8000);
    rd(6'h24, v);
    `CHK("run hi", 8'hFF, v);
    do @(posedge clock); while (!ovfIrq_q[2]);
    `CHK("irq", 3'h4, ovfIrq_q);
    @(posedge clock);
    `CHK("irq end", 3'h0, ovfIrq_q);
    rd(6'h24, v);
    `CHK("reload", 8'h80, v);
    rd(6'h20, l);
    repeat (20) @(posedge clock);
    rd(6'h20, v);
    `CHK("low buf", l, v);
    wr(6'h28, 8'h00);
  endtask
  task automatic tEvent;
    for (int ch = 0; ch < 2; ch++) begin
      for (int e = 0; e < 2; e++) begin
        wr(6'(ch * 16 + 8), 8'h00);
        wr16(6'(ch * 16), 16'h0000);
        wr(6'(ch * 16 + 8), 8'(8'h50 | (e << 3)));
        pm.pulses(ch, 3 + e, 1'b0, 6);
        rd16(6'(ch * 16), w);
        `CHK("events", 16'(3 + e), w);
      end
    end
  endtask
  task automatic tPulse;
    wr(6'h08, 8'h00);
    pm.pulses(0, 0, 1'b1, 6);
    wr16(6'h00, 16'h0000);
    wr(6'h08, 8'hD0);
    pm.pulses(0, 1, 1'b1, 40);
    rd(6'h08, v);
    `CHK("run clr", 8'hC0, v);
    rd16(6'h00, w);
    `CHK("width", 1'b1, w >= 16'h0009 && w <= 16'h000B);
  endtask
  task automatic tSlowAndBad;
    // Counter one is still running in event mode and must stop before the preload.
    wr(6'h18, 8'h00);
    wr16(6'h10, 16'h0000);
    wr(6'h18, 8'h90);
    repeat (1500) @(posedge clock);
    wr(6'h18, 8'h00);
    rd16(6'h10, w);
    `CHK("lf ticks", 1'b1, w == 16'h0002 || w == 16'h0003);
    rd(6'h30, v);
    `CHK("bad rd", `TTEC_RESP_SLVERR, resp);
    wr(6'h0C, 8'h55);
    `CHK("bad wr", `TTEC_RESP_SLVERR, resp);
    s_axi_wstrb <= 4'h0;
    wr(6'h28, 8'h10);
    s_axi_wstrb <= 4'hF;
    rd(6'h28, v);
    `CHK("strb off", 8'h00, v);
  endtask
  task automatic endOfTest;
    if (errTotal == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Whole run is a few thousand cycles; the ceiling only catches a hang.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      errTotal++;
      endOfTest;
    end
  end
  initial begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    tBuffer;
    tReload;
    tEvent;
    tPulse;
    tSlowAndBad;
    endOfTest;
  end
endmodule
bind ttec_top ttec_props chk (.clock, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .ovfIrq_q);
`default_nettype wire
